/* rtl/scw_pkg.sv */
// Package for the serial width and pin configuration block.
// Assumes a 20 MHz APB clock and a byte-wide serial data path per lane.
package scw_pkg;

    // =========================================================
    // Register byte offsets.
    // =========================================================
    localparam logic [7:0] OFS_CTRL_ONE   = 8'h00; // Enable and master bits.
    localparam logic [7:0] OFS_CTRL_TWO   = 8'h04; // Width and pin control.
    localparam logic [7:0] OFS_DATA_HIGH  = 8'h08; // High data byte.
    localparam logic [7:0] OFS_DATA_LOW   = 8'h0C; // Low data byte.
    localparam logic [7:0] OFS_STATUS     = 8'h10; // Sticky event status.
    localparam logic [7:0] OFS_INT_CLEAR  = 8'h14; // Write one to clear.
    localparam logic [7:0] OFS_INT_ENABLE = 8'h18; // Interrupt enable.

    // =========================================================
    // Field positions.
    // =========================================================
    localparam int POS_ENABLE = 0; // Control one: block enable.
    localparam int POS_MASTER = 1; // Control one: master mode.
    localparam int POS_WIDTH  = 6; // Control two: transfer width.
    localparam int POS_FDEN   = 4; // Control two: fault detect enable.
    localparam int POS_BIDOE  = 3; // Control two: bidir output enable.
    localparam int POS_WSTOP  = 1; // Control two: wait clock stop.
    localparam int POS_PINCTL = 0; // Control two: bidir pin control.
    localparam int POS_DONE   = 0; // Status: word finished.
    localparam int POS_FAULT  = 1; // Status: mode fault.
    localparam int POS_BUSY   = 2; // Status: live busy indication.

    // =========================================================
    // Reset values and masks.
    // =========================================================
    localparam logic [7:0] RST_CTRL_ONE = 8'h00;
    localparam logic [7:0] RST_CTRL_TWO = 8'h00;
    localparam logic [7:0] MASK_CTRL_TWO = 8'h5B; // Implemented bits.
    localparam logic [1:0] RST_EVENTS   = 2'h0;

    // =========================================================
    // Timing: serial clock half period when acting as master.
    // =========================================================
    localparam int CLK_PERIOD_NS   = 50;
    localparam int SCK_HALF_NS     = 200;
    localparam int SCK_HALF_CYC    = (SCK_HALF_NS + CLK_PERIOD_NS - 1)
                                     / CLK_PERIOD_NS;
    localparam int WORD_LONG       = 16;
    localparam int WORD_SHORT      = 8;

    // Control two fields carried together.
    typedef struct packed {
        logic width16;   // 16-bit transfers when set.
        logic fault_en;  // Mode fault detection enabled.
        logic bidir_oe;  // Output enable in bidirectional mode.
        logic wait_stop; // Stop serial clock in wait mode.
        logic pin_ctl;   // Bidirectional single-pin mode.
    } scw_ctrl_s;

    // Engine states.
    typedef enum logic [0:0] {
        ST_IDLE,
        ST_SHIFT
    } scw_state_e;

endpackage

/* rtl/scw_core.sv */
// Serial interface core with width and pin configuration, APB registers.
// Assumes pins arrive asynchronously and are synchronised here.
//
// Added by the designer: the placing of the registers and register access over APB.
`timescale 1ns/100ps

module scw_core
    import scw_pkg::*;
(
    // APB slave.
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // System state.
    input  wire logic        wait_mode,
    // Serial pins.
    input  wire logic        sck_in,
    output logic             sck_out,
    output logic             sck_oe,
    input  wire logic        mosi_in,
    output logic             mosi_out,
    output logic             mosi_oe,
    input  wire logic        miso_in,
    output logic             miso_out,
    output logic             miso_oe,
    input  wire logic        ss_n_in,
    // Interrupt.
    output logic             irq
);

    // =========================================================
    // Pin synchronisers: stage one feeds stage two only.
    // =========================================================
    logic [3:0] sync1_r;  // First stage of sck, mosi, miso, select.
    logic [3:0] sync2_r;  // Second stage, the only one read.
    logic       sck_d_r;  // Previous synchronised serial clock.

    // Two flip-flops per asynchronous input.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            // Idle levels: select high, clock low, so no false edge.
            sync1_r <= 4'hE;
            sync2_r <= 4'hE;
            sck_d_r <= 1'b0;
        end
        else
        begin
            sync1_r <= {ss_n_in, miso_in, mosi_in, sck_in};
            sync2_r <= sync1_r;
            sck_d_r <= sync2_r[0];
        end
    end

    logic s_sck;   // Synchronised serial clock.
    logic s_mosi;  // Synchronised master-out pin.
    logic s_miso;  // Synchronised master-in pin.
    logic s_ss_n;  // Synchronised select, active low.
    assign s_sck  = sync2_r[0];
    assign s_mosi = sync2_r[1];
    assign s_miso = sync2_r[2];
    assign s_ss_n = sync2_r[3];

    // =========================================================
    // State and next values.
    // =========================================================
    logic [7:0]  ctrl1_r,  ctrl1_nxt;   // Enable and master.
    logic [7:0]  ctrl2_r,  ctrl2_nxt;   // Width and pin control.
    logic [7:0]  txh_r,    txh_nxt;     // High byte to send.
    logic [7:0]  txl_r,    txl_nxt;     // Low byte to send.
    logic [15:0] rx_r,     rx_nxt;      // Last received word.
    logic [1:0]  stat_r,   stat_nxt;    // Sticky events.
    logic [1:0]  ien_r,    ien_nxt;     // Interrupt enables.
    logic [31:0] prdata_r, prdata_nxt;  // Read data.
    logic        pready_r, pready_nxt;  // Access ready.
    logic        perr_r,   perr_nxt;    // Unmapped address.
    scw_state_e  st_r,     st_nxt;      // Engine state.
    logic [15:0] sh_r,     sh_nxt;      // Shift register.
    logic [4:0]  cnt_r,    cnt_nxt;     // Bits still to sample.
    logic [2:0]  div_r,    div_nxt;     // Half period divider.
    logic        sck_r,    sck_nxt;     // Driven serial clock.
    logic        mo_r,     mo_nxt;      // Master-out level.
    logic        moe_r,    moe_nxt;     // Master-out enable.
    logic        mi_r,     mi_nxt;      // Master-in level.
    logic        mie_r,    mie_nxt;     // Master-in enable.
    logic        irq_r,    irq_nxt;     // Interrupt level.

    scw_ctrl_s c;          // Current control two fields.
    logic      is_master;  // Block enabled as master.
    logic      is_slave;   // Block enabled as slave.
    logic      wr_now;     // Write takes effect this edge.
    logic      rd_now;     // Read data being prepared.
    logic      cfg_change; // Master configuration change this edge.
    logic      tick;       // Master half period enable pulse.
    logic      rx_bit;     // Receive pin chosen by mode.
    logic      top_bit;    // Shift register output bit.
    logic      fault_ev;   // Mode fault seen this cycle.
    logic      done_ev;    // Word completed this cycle.
    logic [7:0] wbyte;     // Written byte.

    assign c          = '{ctrl2_r[POS_WIDTH], ctrl2_r[POS_FDEN],
                          ctrl2_r[POS_BIDOE], ctrl2_r[POS_WSTOP],
                          ctrl2_r[POS_PINCTL]};
    assign is_master  = ctrl1_r[POS_ENABLE] & ctrl1_r[POS_MASTER];
    assign is_slave   = ctrl1_r[POS_ENABLE] & ~ctrl1_r[POS_MASTER];
    assign wr_now     = psel & penable & pready_r & pwrite;
    assign rd_now     = psel & penable & ~pready_r & ~pwrite;
    assign wbyte      = pwdata[7:0];
    assign top_bit    = c.width16 ? sh_r[15] : sh_r[7];

    // A width, fault enable or pin control change in master mode, or an
    // output enable change while bidirectional, stops the word at once.
    assign cfg_change = is_master & wr_now & (paddr == OFS_CTRL_TWO)
        & ((wbyte[POS_WIDTH]  != ctrl2_r[POS_WIDTH])
        |  (wbyte[POS_FDEN]   != ctrl2_r[POS_FDEN])
        |  (wbyte[POS_PINCTL] != ctrl2_r[POS_PINCTL])
        |  (c.pin_ctl & (wbyte[POS_BIDOE] != c.bidir_oe)));

    // Receive pin depends on role and pin mode.
    always_comb
    begin
        if (is_master)
            rx_bit = c.pin_ctl ? s_mosi : s_miso;
        else
            rx_bit = c.pin_ctl ? s_miso : s_mosi;
    end

    // Select low in master mode is a fault only when detection is on;
    // in slave mode the select pin is always an input.
    assign fault_ev = is_master & c.fault_en & ~s_ss_n;

    // Divider pulse; held off in wait mode when the stop bit is set.
    assign tick = (div_r == 3'(SCK_HALF_CYC - 1))
                  & ~(wait_mode & c.wait_stop);

    // =========================================================
    // Register file next values.
    // =========================================================
    always_comb
    begin
        ctrl1_nxt  = ctrl1_r;
        ctrl2_nxt  = ctrl2_r;
        txh_nxt    = txh_r;
        txl_nxt    = txl_r;
        ien_nxt    = ien_r;
        stat_nxt   = stat_r;
        pready_nxt = psel & penable & ~pready_r;
        perr_nxt   = 1'b0;
        prdata_nxt = prdata_r;
        if (pready_nxt)
        begin
            // Address decode for both directions.
            if (paddr == OFS_CTRL_ONE)
                prdata_nxt = {30'h0, ctrl1_r[1:0]};
            else if (paddr == OFS_CTRL_TWO)
                prdata_nxt = {24'h0, ctrl2_r & MASK_CTRL_TWO};
            else if (paddr == OFS_DATA_HIGH)
                prdata_nxt = {24'h0, rx_r[15:8]};
            else if (paddr == OFS_DATA_LOW)
                prdata_nxt = {24'h0, rx_r[7:0]};
            else if (paddr == OFS_STATUS)
                prdata_nxt = {29'h0, st_r == ST_SHIFT, stat_r};
            else if (paddr == OFS_INT_ENABLE)
                prdata_nxt = {30'h0, ien_r};
            else if (paddr == OFS_INT_CLEAR)
                prdata_nxt = 32'h0000_0000;
            else
            begin
                prdata_nxt = 32'h0000_0000;
                perr_nxt   = 1'b1;
            end
            if (!rd_now)
                prdata_nxt = 32'h0000_0000;
        end
        if (wr_now)
        begin
            if (paddr == OFS_CTRL_ONE)
                ctrl1_nxt = {6'h0, wbyte[1:0]};
            else if (paddr == OFS_CTRL_TWO)
                ctrl2_nxt = wbyte & MASK_CTRL_TWO;
            else if (paddr == OFS_DATA_HIGH)
                txh_nxt = wbyte;
            else if (paddr == OFS_DATA_LOW)
                txl_nxt = wbyte;
            else if (paddr == OFS_INT_ENABLE)
                ien_nxt = pwdata[1:0];
            else if (paddr == OFS_INT_CLEAR)
                stat_nxt = stat_r & ~pwdata[1:0];
        end
        // A mode fault drops master mode; events win over a clear.
        if (fault_ev)
            ctrl1_nxt[POS_MASTER] = 1'b0;
        stat_nxt[POS_DONE]  = stat_nxt[POS_DONE] | done_ev;
        stat_nxt[POS_FAULT] = stat_nxt[POS_FAULT] | fault_ev;
        irq_nxt = |(stat_nxt & ien_nxt);
    end

    // =========================================================
    // Serial engine next values.
    // =========================================================
    always_comb
    begin
        st_nxt  = st_r;
        sh_nxt  = sh_r;
        cnt_nxt = cnt_r;
        rx_nxt  = rx_r;
        sck_nxt = sck_r;
        mo_nxt  = mo_r;
        mi_nxt  = mi_r;
        done_ev = 1'b0;
        div_nxt = (st_r == ST_SHIFT && is_master && !tick
                   && !(wait_mode && c.wait_stop))
                  ? div_r + 3'h1 : 3'h0;
        case (st_r)
            ST_IDLE:
            begin
                sck_nxt = 1'b0;
                if (is_master && wr_now && paddr == OFS_DATA_LOW
                    && !fault_ev)
                begin
                    st_nxt  = ST_SHIFT;
                    sh_nxt  = {txh_r, wbyte};
                    cnt_nxt = c.width16 ? 5'(WORD_LONG) : 5'(WORD_SHORT);
                    mo_nxt  = c.width16 ? txh_r[7] : wbyte[7];
                end
                else if (is_slave && !s_ss_n)
                begin
                    st_nxt  = ST_SHIFT;
                    sh_nxt  = {txh_r, txl_r};
                    cnt_nxt = c.width16 ? 5'(WORD_LONG) : 5'(WORD_SHORT);
                    mi_nxt  = c.width16 ? txh_r[7] : txl_r[7];
                end
            end
            ST_SHIFT:
            begin
                if (is_master)
                begin
                    if (cfg_change || fault_ev)
                    begin
                        st_nxt  = ST_IDLE;
                        sck_nxt = 1'b0;
                    end
                    else if (tick && !sck_r)
                    begin
                        sck_nxt = 1'b1;
                        sh_nxt  = {sh_r[14:0], rx_bit};
                        cnt_nxt = cnt_r - 5'h1;
                    end
                    else if (tick)
                    begin
                        sck_nxt = 1'b0;
                        mo_nxt  = top_bit;
                        if (cnt_r == 5'h0)
                        begin
                            st_nxt  = ST_IDLE;
                            rx_nxt  = c.width16 ? sh_r
                                      : {rx_r[15:8], sh_r[7:0]};
                            done_ev = 1'b1;
                        end
                    end
                end
                else if (!is_slave || s_ss_n)
                    st_nxt = ST_IDLE;
                else if (!(wait_mode && c.wait_stop))
                begin
                    // Slave: sample on rising, drive on falling edge.
                    if (s_sck && !sck_d_r)
                    begin
                        sh_nxt  = {sh_r[14:0], rx_bit};
                        cnt_nxt = cnt_r - 5'h1;
                        if (cnt_r == 5'h1)
                        begin
                            st_nxt  = ST_IDLE;
                            rx_nxt  = c.width16 ? sh_nxt
                                      : {rx_r[15:8], sh_nxt[7:0]};
                            done_ev = 1'b1;
                        end
                    end
                    else if (!s_sck && sck_d_r)
                        mi_nxt = top_bit;
                end
            end
            default:
                st_nxt = ST_IDLE;
        endcase
        // Pin drivers by role and pin mode.
        moe_nxt = is_master & (~c.pin_ctl | c.bidir_oe);
        mie_nxt = is_slave & ~s_ss_n
                  & (~c.pin_ctl | c.bidir_oe);
    end

    // =========================================================
    // Registers.
    // =========================================================
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl1_r  <= RST_CTRL_ONE;
            ctrl2_r  <= RST_CTRL_TWO;
            txh_r    <= 8'h00;
            txl_r    <= 8'h00;
            rx_r     <= 16'h0000;
            stat_r   <= RST_EVENTS;
            ien_r    <= RST_EVENTS;
            prdata_r <= 32'h0000_0000;
            pready_r <= 1'b0;
            perr_r   <= 1'b0;
            st_r     <= ST_IDLE;
            sh_r     <= 16'h0000;
            cnt_r    <= 5'h00;
            div_r    <= 3'h0;
            sck_r    <= 1'b0;
            mo_r     <= 1'b0;
            moe_r    <= 1'b0;
            mi_r     <= 1'b0;
            mie_r    <= 1'b0;
            irq_r    <= 1'b0;
        end
        else
        begin
            ctrl1_r  <= ctrl1_nxt;
            ctrl2_r  <= ctrl2_nxt;
            txh_r    <= txh_nxt;
            txl_r    <= txl_nxt;
            rx_r     <= rx_nxt;
            stat_r   <= stat_nxt;
            ien_r    <= ien_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            perr_r   <= perr_nxt;
            st_r     <= st_nxt;
            sh_r     <= sh_nxt;
            cnt_r    <= cnt_nxt;
            div_r    <= div_nxt;
            sck_r    <= sck_nxt;
            mo_r     <= mo_nxt;
            moe_r    <= moe_nxt;
            mi_r     <= mi_nxt;
            mie_r    <= mie_nxt;
            irq_r    <= irq_nxt;
        end
    end

    logic sck_oe_r;  // Serial clock driven, registered role.

    // Outputs straight from flip-flops.
    assign prdata   = prdata_r;
    assign pready   = pready_r;
    assign pslverr  = perr_r;
    assign sck_out  = sck_r;
    assign sck_oe   = sck_oe_r;
    assign mosi_out = mo_r;
    assign mosi_oe  = moe_r;
    assign miso_out = mi_r;
    assign miso_oe  = mie_r;
    assign irq      = irq_r;

    // Serial clock is driven whenever the block is master.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sck_oe_r <= 1'b0;
        else
            sck_oe_r <= is_master;
    end

    // =========================================================
    // Checks.
    // =========================================================
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_cfg_abort: assert property (cfg_change |=> st_r == ST_IDLE)
        else $error("master config change did not abort");
    chk_oe_abort: assert property (is_master && c.pin_ctl && wr_now
        && paddr == OFS_CTRL_TWO && wbyte[POS_BIDOE] != c.bidir_oe
        |=> st_r == ST_IDLE)
        else $error("output enable change did not abort");
    chk_width_mask: assert property (
        (ctrl2_r & ~MASK_CTRL_TWO) == 8'h00)
        else $error("unused control bit set");
    chk_fault_off: assert property (is_master && !c.fault_en
        |=> !$rose(stat_r[POS_FAULT]))
        else $error("fault flagged while detection off");
    chk_fault_on: assert property (fault_ev |=> stat_r[POS_FAULT]
        && !ctrl1_r[POS_MASTER])
        else $error("mode fault not flagged");
    chk_slave_ss: assert property (is_slave |-> !fault_ev)
        else $error("slave raised mode fault");
    // The enable is registered one cycle behind the control fields.
    chk_bidir_oe: assert property (is_master && c.pin_ctl
        && !c.bidir_oe |=> !mosi_oe)
        else $error("master-out driven with enable off");
    chk_normal_pins: assert property (is_master && !c.pin_ctl
        |=> mosi_oe && !miso_oe)
        else $error("master normal pins wrong");
    chk_slave_bidir: assert property (is_slave && c.pin_ctl
        |=> !mosi_oe)
        else $error("slave drove master-out in bidir");
    // An abort may still pull the clock low; only generation is held.
    chk_wait_stop: assert property (wait_mode && c.wait_stop
        && st_r == ST_SHIFT && !cfg_change && !fault_ev
        |=> $stable(sck_r))
        else $error("serial clock ran in wait stop");
    chk_abort_keep: assert property (cfg_change
        |=> $stable(rx_r) && $stable(stat_r[POS_DONE]))
        else $error("abort changed received data");

    cov_master_word: cover property (is_master && done_ev);
    cov_slave_word:  cover property (is_slave && done_ev);
    cov_abort:       cover property (cfg_change && st_r == ST_SHIFT);
    cov_fault:       cover property (fault_ev);

endmodule

/* dv/scw_partner.sv */
// Far-side serial slave model for the width and pin configuration block.
// Assumes mode 0 framing, MSB first, and a word preloaded before a frame.
`timescale 1ns/100ps

// =============================================================
// Behavioural slave: shifts a preloaded word out, collects input.
// =============================================================
module scw_partner
(
    // Serial pins seen from the far side.
    input  wire logic        sck,
    input  wire logic        mosi,
    output logic             miso,
    // Word handling.
    input  wire logic        load,
    input  wire logic [15:0] tx_word,
    output logic      [15:0] rx_word
);
    logic [15:0] shift_r; // Outgoing bits, MSB presented on the pin.

    // Preload the outgoing word while idle, left aligned, then present the
    // next bit on each falling clock edge; one process owns the register.
    always @(posedge load or negedge sck)
    begin
        if (load)
            shift_r <= tx_word;
        else
            shift_r <= {shift_r[14:0], ~shift_r[0]};
    end

    // Sample the master's output on the rising clock edge.
    always @(posedge sck)
    begin
        rx_word <= {rx_word[14:0], mosi};
    end

    assign miso = shift_r[15];
endmodule

/* dv/tb.sv */
// Self-checking bench for the serial width and pin configuration block.
// Assumes the design acts as master and a slave model sits on its pins.
`timescale 1ns/100ps

module tb;
    import scw_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, wait_mode, load;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, err, irq, sck_out, sck_oe, ss_pin;
    logic        mosi_out, mosi_oe, miso_out, miso_oe, miso_pin, mosi_pin;
    logic [15:0] tx_word, rx_word, hold_rx;
    logic [7:0]  ab_tab [4][2];
    int          num_errors, cmp_count;

    // Pin levels: a released master-out pin shows the inverse of the far end's value.
    assign mosi_pin = mosi_oe ? mosi_out : ~miso_pin;

    scw_core dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .wait_mode(wait_mode), .sck_in(1'b0), .sck_out(sck_out),
        .sck_oe(sck_oe), .mosi_in(mosi_pin), .mosi_out(mosi_out),
        .mosi_oe(mosi_oe), .miso_in(miso_oe ? miso_out : miso_pin),
        .miso_out(miso_out), .miso_oe(miso_oe), .ss_n_in(ss_pin), .irq(irq));

    scw_partner peer_u (.sck(sck_out), .mosi(mosi_pin), .miso(miso_pin),
        .load(load), .tx_word(tx_word), .rx_word(rx_word));

    // =========================================================
    // Clock, comparison and closing.
    // =========================================================
    initial
    begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim;
        $display("Checks %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // One APB transfer; holds the request until pready is sampled high.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Poll status until the word is done, bounded.
    task automatic wait_done;
        int k;
        k = 0;
        do
        begin
            apb(1'b0, OFS_STATUS, 32'h0);
            k++;
        end
        while (rd[POS_DONE] !== 1'b1 && k < 100);
        chk({31'h0, rd[POS_DONE]}, 32'h1);
    endtask

    // One master word; the model expects the slave's word back in data.
    task automatic xfer(input logic w16, input logic [15:0] tw,
                        input logic [15:0] pw);
        apb(1'b1, OFS_INT_CLEAR, 32'h3);
        tx_word <= w16 ? pw : {pw[7:0], 8'h00};
        load    <= 1'b1;
        @(posedge pclk);
        load <= 1'b0;
        apb(1'b1, OFS_DATA_HIGH, {24'h0, tw[15:8]});
        apb(1'b1, OFS_DATA_LOW, {24'h0, tw[7:0]});
        if (wait_mode)
        begin
            // The word must sit busy with the clock held low.
            repeat (150) @(posedge pclk);
            apb(1'b0, OFS_STATUS, 32'h0);
            chk(rd, 32'h4);
            chk({31'h0, sck_out}, 32'h0);
            wait_mode <= 1'b0;
        end
        wait_done();
        chk(w16 ? rx_word : {8'h0, rx_word[7:0]}, w16 ? tw : tw[7:0]);
        apb(1'b0, OFS_DATA_LOW, 32'h0);
        chk(rd, {24'h0, pw[7:0]});
        hold_rx = pw;
        apb(1'b0, OFS_DATA_HIGH, 32'h0);
        if (w16)
            chk(rd, {24'h0, pw[15:8]});
    endtask

    // =========================================================
    // Watchdog and main sequence.
    // =========================================================
    initial
    begin
        #2000000;
        num_errors++;
        end_sim();
    end

    initial
    begin
        {psel, penable, pwrite, wait_mode, load, ss_pin} = 6'h01;
        {paddr, pwdata, tx_word} = '0;
        {num_errors, cmp_count} = '0;
        ab_tab = '{'{8'h00, 8'h40}, '{8'h40, 8'h10}, '{8'h01, 8'h00},
                   '{8'h09, 8'h01}};
        presetn = 1'b0;
        void'($urandom(32'h78E93CE3));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, OFS_CTRL_TWO, 32'h0);
        chk(rd, {24'h0, RST_CTRL_TWO});
        apb(1'b1, OFS_CTRL_TWO, 32'hFF);
        apb(1'b0, OFS_CTRL_TWO, 32'h0);
        chk(rd, {24'h0, MASK_CTRL_TWO});
        apb(1'b0, 8'hFC, 32'h0);
        chk({31'h0, err}, 32'h1);
        apb(1'b1, OFS_CTRL_ONE, 32'h3);
        apb(1'b1, OFS_CTRL_TWO, 32'h01);
        repeat (3) @(posedge pclk);
        chk({30'h0, mosi_oe, miso_oe}, 32'h0);
        apb(1'b1, OFS_CTRL_TWO, 32'h00);
        repeat (3) @(posedge pclk);
        chk({29'h0, sck_oe, mosi_oe, miso_oe}, 32'h6);
        apb(1'b1, OFS_INT_ENABLE, 32'h1);
        xfer(1'b0, 16'($urandom), 16'($urandom));
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, OFS_INT_ENABLE, 32'h0);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, OFS_CTRL_TWO, 32'h40);
        xfer(1'b1, 16'($urandom), 16'($urandom));
        // Configuration changes in mid-word must drop the word.
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b1, OFS_CTRL_TWO, {24'h0, ab_tab[i][0]});
            apb(1'b1, OFS_INT_CLEAR, 32'h3);
            apb(1'b1, OFS_DATA_LOW, 32'($urandom) & 32'hFF);
            apb(1'b1, OFS_CTRL_TWO, {24'h0, ab_tab[i][1]});
            repeat (150) @(posedge pclk);
            apb(1'b0, OFS_STATUS, 32'h0);
            chk(rd, 32'h0);
            apb(1'b0, OFS_DATA_LOW, 32'h0);
            chk(rd, {24'h0, hold_rx[7:0]});
        end
        // Select low is a fault only with detection on; the fault drops
        // master mode and the block then answers as a selected slave.
        ss_pin <= 1'b0;
        apb(1'b1, OFS_CTRL_TWO, 32'h00);
        repeat (6) @(posedge pclk);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, OFS_CTRL_TWO, 32'h10);
        repeat (6) @(posedge pclk);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(rd, 32'h6);
        apb(1'b0, OFS_CTRL_ONE, 32'h0);
        chk(rd, 32'h1);
        chk({29'h0, sck_oe, mosi_oe, miso_oe}, 32'h1);
        apb(1'b1, OFS_CTRL_TWO, 32'h11);
        repeat (3) @(posedge pclk);
        chk({30'h0, mosi_oe, miso_oe}, 32'h0);
        ss_pin <= 1'b1;
        apb(1'b1, OFS_CTRL_ONE, 32'h3);
        // A stopped clock in wait mode keeps the word pending.
        apb(1'b1, OFS_CTRL_TWO, 32'h02);
        wait_mode <= 1'b1;
        xfer(1'b0, 16'($urandom), 16'($urandom));
        end_sim();
    end
endmodule
